// ### rtl/nv_cfg_pkg.sv
// Package: register map, field positions, reset values and timing constants of the flash configuration block
package nv_cfg_pkg;
  // ==========================================================================
  // Register byte addresses on the Avalon-MM slave
  localparam logic [3:0] ADDR_CLOCK_RATIO = 4'h0;
  localparam logic [3:0] ADDR_OPTION_COPY = 4'h4;
  localparam logic [3:0] ADDR_FLASH_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'hC;
  // ==========================================================================
  // Field positions
  localparam int RATIO_LOADED_BIT = 7;
  localparam int PRESCALE_BIT     = 6;
  localparam int DIVISOR_MSB      = 5;
  localparam int KEY_ENABLE_BIT   = 7;
  localparam int REDIRECT_DIS_BIT = 6;
  localparam int SEC_CODE_MSB     = 1;
  localparam int KEY_SELECT_BIT   = 5;
  localparam int IRQ_MASK_LSB     = 8;
  // ==========================================================================
  // Values
  localparam logic [1:0] SEC_UNSECURED     = 2'h2;
  localparam logic [7:0] CLOCK_RATIO_RESET = 8'h00;
  localparam logic [7:0] FLASH_CONFIG_RESET = 8'h00;
  // Erased pattern: secure until the stored byte has been copied in
  localparam logic [7:0] OPTION_COPY_RESET  = 8'hFF;
  localparam int         PRESCALE_FACTOR   = 8;
  localparam int         KEY_BYTES         = 8;
  localparam logic [15:0] KEY_BASE_ADDR    = 16'hFFB0;
  // Interrupt status bits
  localparam int IRQ_ACCESS_ERROR = 0;
  localparam int IRQ_UNLOCKED     = 1;
  localparam int IRQ_KEY_FAIL     = 2;
  localparam int IRQ_WIDTH        = 3;
  // ==========================================================================
  // Timing
  localparam int CLOCK_HZ        = 100_000_000;
  localparam int PULSE_MIN_NS    = 5000;
  localparam int PULSE_MAX_NS    = 6700;
  localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_MAX_CYCLES = (PULSE_MAX_NS * (CLOCK_HZ / 1_000_000)) / 1000;
endpackage

// ### rtl/timing_divider.sv
// Module: divider that builds the program/erase timing clock from the bus clock
`timescale 1ns/100ps
module timing_divider
  import nv_cfg_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       run_in,
  input  wire logic       prescale_in,
  input  wire logic [5:0] divisor_in,
  output logic            tick_out
);
  // ==========================================================================
  // Prescaler by eight
  logic [2:0] pre_count;
  logic [5:0] div_count;
  wire        pre_tick = prescale_in ? (pre_count == 3'(PRESCALE_FACTOR - 1)) : 1'b1;
  wire        div_wrap = (div_count == divisor_in);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !run_in) begin
      pre_count <= 3'h0;
      div_count <= 6'h00;
      tick_out  <= 1'b0;
    end else begin
      pre_count <= pre_tick ? 3'h0 : pre_count + 3'h1;
      tick_out  <= pre_tick && div_wrap;
      if (pre_tick) begin
        div_count <= div_wrap ? 6'h00 : div_count + 6'h01;
      end
    end
  end
endmodule

// ### rtl/key_store.sv
// Module: eight-byte capture of backdoor key comparison writes
`timescale 1ns/100ps
module key_store
  import nv_cfg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clear_in,
  input  wire logic        write_in,
  input  wire logic [2:0]  index_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [63:0] stored_key_in,
  output logic             match_out
);
  // ==========================================================================
  // Bytes must arrive in ascending order; any skip spoils the sequence
  logic [63:0] captured;
  logic [3:0]  next_index;
  logic        in_order;
  wire         expected = (index_in == next_index[2:0]) && !next_index[3];

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || clear_in) begin
      captured   <= 64'h0000000000000000;
      next_index <= 4'h0;
      in_order   <= 1'b1;
    end else if (write_in) begin
      captured[index_in*8 +: 8] <= data_in;
      next_index <= next_index + 4'h1;
      if (!expected) begin
        in_order <= 1'b0;
      end
    end
  end

  assign match_out = in_order && (next_index == 4'(KEY_BYTES)) && (captured == stored_key_in);
endmodule

// ### rtl/flash_clock_and_security_options.sv
// Module: flash clock ratio, option copy, key access and security state with Avalon-MM slave
`timescale 1ns/100ps
// Notes on behaviour
// - Loaded flag on top; ratio bits write once
// - No program or erase until ratio written
// - Reset clears loaded flag; first write sets
// - Bit six prescales bus clock by eight
// - Divide selected clock by divisor plus one
// - Pulses are one timing clock period each
// - Option copy loaded from stored byte after reset release
// - Key unlock disabled when enable bit zero
// - Only secure firmware key writes count
// - Eight ascending matching key bytes unsecure device
// - Option bit six disables vector redirection
// - Only code 1:0 means unsecured
// - Secure device blocks unsecured memory access
// - Key match or blank check unsecures
// - Key select steers key range writes
// - Clearing key select triggers key compare
// - Early program attempt ignored, sets access error
module flash_clock_and_security_options
  import nv_cfg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             avs_response_error_out,
  // Nonvolatile contents presented by the array
  input  wire logic [7:0]  stored_option_byte_in,
  input  wire logic [63:0] stored_unlock_key_in,
  // Processor writes into flash space
  input  wire logic        array_write_in,
  input  wire logic [15:0] array_addr_in,
  input  wire logic [7:0]  array_data_in,
  input  wire logic        source_secure_in,
  input  wire logic        blank_check_pass_in,
  // Memory access gating
  input  wire logic        mem_access_req_in,
  output logic             mem_access_grant_out,
  // Toward command engine
  output logic             command_start_out,
  output logic             access_error_out,
  output logic             nv_timing_tick_out,
  output logic             redirect_disable_out,
  output logic             secure_out,
  output logic             irq_out
);
  // ==========================================================================
  // State
  logic [6:0]           ratio_bits;
  logic                 ratio_loaded_flag;
  logic [7:0]           option_copy;
  logic                 option_loaded;
  logic                 key_write_select;
  logic                 unlocked;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic                 rd_pending;
  logic [31:0]          read_word;
  logic                 key_match;

  // ==========================================================================
  // Bus decode; every access finishes one cycle after it is seen
  wire access      = avs_read_in || avs_write_in;
  wire finish      = access && rd_pending;
  wire sel_ratio   = (avs_address_in == ADDR_CLOCK_RATIO);
  wire sel_option  = (avs_address_in == ADDR_OPTION_COPY);
  wire sel_config  = (avs_address_in == ADDR_FLASH_CONFIG);
  wire sel_irq     = (avs_address_in == ADDR_IRQ_STATUS);
  wire mapped      = sel_ratio || sel_option || sel_config || sel_irq;
  wire wr_byte0    = finish && avs_write_in && avs_byteenable_in[0];
  wire wr_ratio    = wr_byte0 && sel_ratio;
  wire wr_config   = wr_byte0 && sel_config;
  wire wr_mask     = finish && avs_write_in && avs_byteenable_in[1] && sel_irq;
  wire rd_irq      = finish && avs_read_in && sel_irq;

  // ==========================================================================
  // Security and key range
  wire [1:0] security_code = unlocked ? SEC_UNSECURED : option_copy[SEC_CODE_MSB:0];
  wire       secure        = (security_code != SEC_UNSECURED);
  wire       key_enable    = option_copy[KEY_ENABLE_BIT];
  wire       in_key_range  = (array_addr_in[15:3] == KEY_BASE_ADDR[15:3]);
  wire       key_write     = array_write_in && in_key_range && key_write_select;
  wire       key_accepted  = key_write && source_secure_in && key_enable;
  wire       key_close     = wr_config && key_write_select && !avs_writedata_in[KEY_SELECT_BIT];
  wire       unlock_event  = (key_close && key_enable && key_match) || blank_check_pass_in;
  wire       key_fail      = key_close && !(key_enable && key_match);
  wire       cmd_attempt   = array_write_in && !(in_key_range && key_write_select);
  wire       early_attempt = cmd_attempt && !ratio_loaded_flag;
  wire [IRQ_WIDTH-1:0] events = {key_fail, unlock_event, early_attempt};

  // ==========================================================================
  // Read mux; reserved bits read zero
  wire [7:0] ratio_word  = {ratio_loaded_flag, ratio_bits};
  wire [7:0] config_word = {2'h0, key_write_select, 5'h00};
  always_comb begin
    case (avs_address_in)
      ADDR_CLOCK_RATIO:  read_word = {24'h000000, ratio_word};
      ADDR_OPTION_COPY:  read_word = {24'h000000, option_copy};
      ADDR_FLASH_CONFIG: read_word = {24'h000000, config_word};
      ADDR_IRQ_STATUS:   read_word = {21'h0, irq_mask, 5'h00, irq_status};
      default:           read_word = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Bus handshake
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_pending             <= 1'b0;
      avs_readdata_out       <= 32'h00000000;
      avs_response_error_out <= 1'b0;
    end else begin
      rd_pending <= access && !rd_pending;
      if (access && !rd_pending) begin
        avs_readdata_out       <= avs_read_in ? read_word : 32'h00000000;
        avs_response_error_out <= !mapped;
      end
    end
  end
  assign avs_waitrequest_out = access && !rd_pending;

  // ==========================================================================
  // Clock ratio register, written once
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ratio_bits        <= CLOCK_RATIO_RESET[6:0];
      ratio_loaded_flag <= CLOCK_RATIO_RESET[RATIO_LOADED_BIT];
    end else if (wr_ratio && !ratio_loaded_flag) begin
      ratio_bits        <= avs_writedata_in[6:0];
      ratio_loaded_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // Option copy: loaded after reset release, no software path in
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      option_copy   <= OPTION_COPY_RESET;
      option_loaded <= 1'b0;
    end else if (!option_loaded) begin
      option_copy   <= stored_option_byte_in;
      option_loaded <= 1'b1;
    end
  end

  // ==========================================================================
  // Key select and temporary unlock, held until the next reset
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      key_write_select <= FLASH_CONFIG_RESET[KEY_SELECT_BIT];
      unlocked         <= 1'b0;
    end else begin
      if (wr_config) begin
        key_write_select <= avs_writedata_in[KEY_SELECT_BIT];
      end
      if (unlock_event) begin
        unlocked <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Interrupts; an event in the clearing read's cycle is kept
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (rd_irq ? '0 : irq_status) | events;
      if (wr_mask) begin
        irq_mask <= avs_writedata_in[IRQ_MASK_LSB +: IRQ_WIDTH];
      end
    end
  end
  assign irq_out = |(irq_status & irq_mask);

  // ==========================================================================
  // Submodules
  key_store u_key_store (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .clear_in      (wr_config && avs_writedata_in[KEY_SELECT_BIT] && !key_write_select),
    .write_in      (key_accepted),
    .index_in      (array_addr_in[2:0]),
    .data_in       (array_data_in),
    .stored_key_in (stored_unlock_key_in),
    .match_out     (key_match)
  );

  // Divider only runs once the ratio is fixed, so no half-setup pulses appear
  timing_divider u_timing_divider (
    .ref_clk_in  (ref_clk_in),
    .reset_in    (reset_in),
    .run_in      (ratio_loaded_flag),
    .prescale_in (ratio_bits[PRESCALE_BIT]),
    .divisor_in  (ratio_bits[DIVISOR_MSB:0]),
    .tick_out    (nv_timing_tick_out)
  );

  // ==========================================================================
  // Outputs
  assign command_start_out    = cmd_attempt && ratio_loaded_flag;
  assign access_error_out     = early_attempt;
  assign redirect_disable_out = option_copy[REDIRECT_DIS_BIT];
  assign secure_out           = secure;
  assign mem_access_grant_out = mem_access_req_in && (!secure || source_secure_in);
endmodule

// ### verification/flash_cfg_checker.sv
// Checker: port-level properties of the flash clock and security block
`timescale 1ns/100ps
// ==========================================
// Checker
module flash_cfg_checker
  import nv_cfg_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic [3:0] avs_address_in,
  input wire logic       avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [7:0] stored_option_byte_in,
  input wire logic       array_write_in,
  input wire logic       source_secure_in,
  input wire logic       blank_check_pass_in,
  input wire logic       mem_access_req_in,
  input wire logic       mem_access_grant_out,
  input wire logic       command_start_out,
  input wire logic       access_error_out,
  input wire logic       nv_timing_tick_out,
  input wire logic       redirect_disable_out,
  input wire logic       secure_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic loaded;
  wire  ratio_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_CLOCK_RATIO && avs_byteenable_in[0];
  // Own copy of the loaded flag, so the design's flag is not trusted
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      loaded <= 1'b0;
    end else if (ratio_wr) begin
      loaded <= 1'b1;
    end
  end
  property p_grant; mem_access_grant_out == (mem_access_req_in && (!secure_out || source_secure_in)); endproperty
  a_grant: assert property (p_grant) else $error("grant wrong");
  property p_start; command_start_out |-> array_write_in && loaded; endproperty
  a_start: assert property (p_start) else $error("start without loaded ratio");
  property p_error; access_error_out |-> array_write_in && !loaded; endproperty
  a_error: assert property (p_error) else $error("access error wrong");
  property p_tick; nv_timing_tick_out |-> loaded; endproperty
  a_tick: assert property (p_tick) else $error("tick before ratio");
  property p_load;
    $fell(reset_in) |=> secure_out == (stored_option_byte_in[1:0] != SEC_UNSECURED)
      && redirect_disable_out == stored_option_byte_in[REDIRECT_DIS_BIT];
  endproperty
  a_load: assert property (p_load) else $error("option load wrong");
  property p_hold; !$past(reset_in) && !$past(reset_in, 2) |-> $stable(redirect_disable_out); endproperty
  a_hold: assert property (p_hold) else $error("option changed");
  property p_blank; blank_check_pass_in |=> !secure_out; endproperty
  a_blank: assert property (p_blank) else $error("blank check no unlock");
  property p_key_unlock_enable;
    $fell(secure_out) && !$past(reset_in, 2) && !$past(blank_check_pass_in) |-> stored_option_byte_in[KEY_ENABLE_BIT];
  endproperty
  a_key_unlock_enable: assert property (p_key_unlock_enable) else $error("unlock with key disabled");
  c_unlock: cover property ($fell(secure_out));
  c_tick: cover property (nv_timing_tick_out);
  c_error: cover property (access_error_out);
endmodule
bind flash_clock_and_security_options flash_cfg_checker u_flash_cfg_checker (.ref_clk_in, .reset_in,
  .avs_address_in, .avs_write_in, .avs_byteenable_in, .avs_waitrequest_out, .stored_option_byte_in,
  .array_write_in, .source_secure_in, .blank_check_pass_in, .mem_access_req_in, .mem_access_grant_out,
  .command_start_out, .access_error_out, .nv_timing_tick_out, .redirect_disable_out, .secure_out);

// ### verification/tb.sv
// Testbench: directed scenarios for the flash clock and security block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ==========================================
// Bench
module tb
  import nv_cfg_pkg::*;
;
  logic        ref_clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out, avs_response_error_out;
  logic [3:0]  avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [7:0]  stored_option_byte_in, array_data_in;
  logic [63:0] stored_unlock_key_in;
  logic [15:0] array_addr_in;
  logic        array_write_in, source_secure_in, blank_check_pass_in, mem_access_req_in, mem_access_grant_out;
  logic        command_start_out, access_error_out, nv_timing_tick_out, redirect_disable_out, secure_out, irq_out;
  logic        er, cs, ae;
  int          num_errors, n_compared, cycles;
  flash_clock_and_security_options u_flash_clock_and_security_options (.ref_clk_in, .reset_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .avs_response_error_out, .stored_option_byte_in, .stored_unlock_key_in, .array_write_in, .array_addr_in,
    .array_data_in, .source_secure_in, .blank_check_pass_in, .mem_access_req_in, .mem_access_grant_out,
    .command_start_out, .access_error_out, .nv_timing_tick_out, .redirect_disable_out, .secure_out, .irq_out);
  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Ceiling well above the roughly 1200 cycles the scenarios need
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task stop_test();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Waits for the answer however long it takes; only the cycle ceiling ends a hang
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_read_in <= !wr; avs_write_in <= wr; avs_address_in <= a; avs_writedata_in <= d;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge ref_clk_in);
    end
    rd = avs_readdata_out; er = avs_response_error_out;
    avs_read_in <= 1'b0; avs_write_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task awr(input logic [15:0] a, input logic [7:0] d);
    array_write_in <= 1'b1; array_addr_in <= a; array_data_in <= d;
    #1 cs = command_start_out; ae = access_error_out;
    @(posedge ref_clk_in);
    array_write_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task do_reset(input logic [7:0] opt);
    reset_in <= 1'b1; stored_option_byte_in <= opt;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  // Key bytes go out ascending; bad picks one byte to corrupt, 8 means none
  task send_key(input int bad, input logic src);
    bus(1'b1, ADDR_FLASH_CONFIG, 32'h20);
    source_secure_in <= src;
    for (int i = 0; i < KEY_BYTES; i++) begin
      awr(KEY_BASE_ADDR + 16'(i), stored_unlock_key_in[8*i +: 8] ^ 8'(i == bad));
      `CHK("key path start", 1'b0, cs)
    end
    bus(1'b1, ADDR_FLASH_CONFIG, 32'h0);
  endtask
  task t_regs();
    bus(1'b0, ADDR_CLOCK_RATIO, 32'h0); `CHK("ratio reset", 32'h0, rd)
    bus(1'b1, ADDR_OPTION_COPY, 32'h0);
    bus(1'b0, ADDR_OPTION_COPY, 32'h0); `CHK("option copy", 32'hC0, rd)
    bus(1'b0, 4'h1, 32'h0); `CHK("unmapped error", 1'b1, er)
    `CHK("redirect", 1'b1, redirect_disable_out)
    `CHK("grant secured", 1'b0, mem_access_grant_out)
    $display("end regs");
  endtask
  task t_early();
    awr(16'h8000, 8'h55); `CHK("early error", 1'b1, ae)
    `CHK("early start", 1'b0, cs)
    bus(1'b1, ADDR_IRQ_STATUS, 32'h100); `CHK("irq raised", 1'b1, irq_out)
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0); `CHK("irq status", 3'h1, rd[2:0])
    `CHK("irq cleared", 1'b0, irq_out)
    $display("end early");
  endtask
  task t_key();
    send_key(3, 1'b1); `CHK("bad key", 1'b1, secure_out)
    send_key(8, 1'b0); `CHK("insecure source key", 1'b1, secure_out)
    send_key(8, 1'b1); `CHK("good key", 1'b0, secure_out)
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK("key irq status", 3'h6, rd[2:0])
    $display("end key");
  endtask
  task t_ratio(input logic [7:0] v, input int per);
    int n;
    bus(1'b1, ADDR_CLOCK_RATIO, {24'h0, v});
    bus(1'b1, ADDR_CLOCK_RATIO, {24'h0, ~v});
    bus(1'b0, ADDR_CLOCK_RATIO, 32'h0); `CHK("ratio", {24'h0, 1'b1, v[6:0]}, rd)
    n = 0;
    while (nv_timing_tick_out !== 1'b1 && n < 1000) begin @(posedge ref_clk_in); n++; end
    n = 0;
    do begin @(posedge ref_clk_in); n++; end while (nv_timing_tick_out !== 1'b1 && n < 1000);
    `CHK("tick period", per, n)
    awr(16'h8000, 8'h0); `CHK("start", 1'b1, cs)
    $display("end ratio");
  endtask
  task t_codes();
    for (int c = 0; c < 4; c++) begin
      do_reset(8'(c)); `CHK("security code", 1'(c != 2), secure_out)
    end
    send_key(8, 1'b1); `CHK("key disabled", 1'b1, secure_out)
    blank_check_pass_in <= 1'b1; @(posedge ref_clk_in);
    blank_check_pass_in <= 1'b0; @(posedge ref_clk_in);
    `CHK("blank unlock", 1'b0, secure_out)
    `CHK("redirect", 1'b0, redirect_disable_out)
    source_secure_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK("grant unsecured", 1'b1, mem_access_grant_out)
    $display("end codes");
  endtask
  initial begin
    reset_in = 1; avs_read_in = 0; avs_write_in = 0; avs_address_in = 0; avs_writedata_in = 0;
    avs_byteenable_in = 4'hF; stored_option_byte_in = 8'hC0; stored_unlock_key_in = 64'h8877665544332211;
    array_write_in = 0; array_addr_in = 0; array_data_in = 0; source_secure_in = 0;
    blank_check_pass_in = 0; mem_access_req_in = 1; num_errors = 0; n_compared = 0; cycles = 0;
    do_reset(8'hC0);
    t_regs();
    t_early();
    t_key();
    // Prescale on, divisor 62: 100 MHz / 504 keeps the timing clock near 198 kHz
    t_ratio(8'h7E, 504);
    do_reset(8'hC0);
    t_ratio(8'h01, 2);
    t_codes();
    stop_test();
  end
endmodule
